// File: hdl/pds_cfg.svh
// Purpose: Constants for the synthesizer serial control and divider block
// Assumes: Included by the package users; definitions only
// Notes:   Timing figures are in their printed units; cycle counts derive in the module
`ifndef PDS_CFG_SVH
`define PDS_CFG_SVH
// Serial word
`define PDS_WORD_W      24
// Latch reset values: R = 1, width code 10, B = 3, A = 0, all functions off
`define PDS_REF_RST     24'h020004
`define PDS_FB_RST      24'h000301
`define PDS_FUNC_RST    24'h000002
// Prescaler base modulus P = 8 << select
`define PDS_PRE_BASE    7'h08
// Anti-backlash code for the recommended width
`define PDS_ABP_REC     2'h2
// Timing
`define PDS_CLK_MHZ     100
`define PDS_BACKLASH_PS 7200
`define PDS_LOCK_WIDE_NS 10
`define PDS_LOCK_FINE_NS 3
`define PDS_UNLOCK_NS   25
`define PDS_LOCK_CYCLES 3'h5
`endif

// File: hdl/pds_pkg.sv
// Purpose: Types for the synthesizer serial control and divider block
// Assumes: Field layouts follow the 24-bit programming word, bit 23 first
// Notes:   Struct members run from the most significant bit down
package pds_pkg;
   typedef logic [2:0] pds_cur_t;
   // Latch targets, codes 0..3 in order
   typedef enum logic [1:0] {PDS_TGT_REF, PDS_TGT_FB, PDS_TGT_FUNC, PDS_TGT_NONE} pds_target_e;
   // Monitor pin sources, codes 0..7 in order
   typedef enum logic [2:0] {
      PDS_MON_OFF, PDS_MON_DLOCK, PDS_MON_FB_DIV, PDS_MON_HIGH,
      PDS_MON_REF_DIV, PDS_MON_ALOCK, PDS_MON_SER_DATA, PDS_MON_LOW
   } pds_mon_e;
   typedef struct packed {
      logic [5:0]  reserved;
      logic [1:0]  backlash_width;    // backlash_width_hi, backlash_width_lo
      logic [13:0] ref_div;
      logic [1:0]  target;
   } pds_ref_latch_s;
   typedef struct packed {
      logic        reserved_hi;
      logic        lock_precision_select;
      logic        reserved_lo;
      logic [12:0] main_div;
      logic [5:0]  swallow_div;
      logic [1:0]  target;
   } pds_fb_latch_s;
   typedef struct packed {
      logic [1:0]  prescale_select;
      logic [3:0]  reserved_hi;
      pds_cur_t    pump_current_sel;
      logic [5:0]  reserved_lo;
      logic        pump_tristate;
      logic        pd_polarity;
      logic [2:0]  monitor_select;
      logic        power_down;
      logic        counter_reset;
      logic [1:0]  target;
   } pds_func_latch_s;
endpackage

// File: hdl/pds_synth_ctrl.sv
// Purpose: Serial programming, R/A/B dividers, phase comparator and lock detect
// Assumes: All pins are sampled by clk through two flip-flops; divider inputs slow vs clk
// Notes:   Phase error is measured in whole clk cycles, so precision is 10 ns
`timescale 1ns/100ps
`include "pds_cfg.svh"

module pds_synth_ctrl (
   // Clock and reset
   input  wire logic             clk,
   input  wire logic             rst_n,
   // Three-wire programming pins
   input  wire logic             ser_clk,
   input  wire logic             ser_data,
   input  wire logic             latch_load_strobe,
   // Divider inputs
   input  wire logic             reference_input,
   input  wire logic             rf_input,
   // Charge pump controls
   output logic                  pump_up,
   output logic                  pump_dn,
   output logic                  pump_tristate,
   output pds_pkg::pds_cur_t     pump_current,
   // Status
   output logic                  lock_detect,
   output logic                  ref_stage_en,
   // Monitor pin, drive and enable
   output logic                  monitor_o,
   output logic                  monitor_oe
);
   import pds_pkg::*;

   // Cycle counts from the printed times; limits round down, least times up
   localparam int WIDE_RAW = `PDS_LOCK_WIDE_NS * `PDS_CLK_MHZ / 1000;
   localparam int FINE_RAW = `PDS_LOCK_FINE_NS * `PDS_CLK_MHZ / 1000;
   localparam int UNLK_RAW = (`PDS_UNLOCK_NS * `PDS_CLK_MHZ + 999) / 1000;
   localparam int ABP_RAW  = (`PDS_BACKLASH_PS * `PDS_CLK_MHZ + 999999) / 1000000;
   localparam logic [7:0] WIDE_CYC = 8'((WIDE_RAW < 1) ? 1 : WIDE_RAW);
   localparam logic [7:0] FINE_CYC = 8'((FINE_RAW < 1) ? 1 : FINE_RAW);
   localparam logic [7:0] UNLK_CYC = 8'((UNLK_RAW < 1) ? 1 : UNLK_RAW);
   localparam logic [3:0] ABP_CYC  = 4'((ABP_RAW < 1) ? 1 : ABP_RAW);

   // Pin synchronisers: meta -> sync -> last, edges from sync and last only
   logic [4:0] pin_meta_r, pin_sync_r, pin_last_r;
   wire  [4:0] pins = {rf_input, reference_input, latch_load_strobe, ser_data, ser_clk};
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pin_meta_r <= 5'h00;
         pin_sync_r <= 5'h00;
         pin_last_r <= 5'h00;
      end else begin
         pin_meta_r <= pins;
         pin_sync_r <= pin_meta_r;
         pin_last_r <= pin_sync_r;
      end
   end
   wire [4:0] pin_rise = pin_sync_r & ~pin_last_r;
   wire       sclk_rise = pin_rise[0];
   wire       sdata     = pin_sync_r[1];
   wire       load_rise = pin_rise[2];

   // Serial shift register
   logic [23:0] shift_r;
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         shift_r <= 24'h000000;
      end else if (sclk_rise) begin
         shift_r <= {shift_r[22:0], sdata};
      end
   end

   // Latch decode on the strobe edge
   wire pds_target_e tgt       = pds_target_e'(shift_r[1:0]);
   wire              wr_ref    = load_rise && (tgt == PDS_TGT_REF);
   wire              wr_fb     = load_rise && (tgt == PDS_TGT_FB);
   wire              wr_func   = load_rise && (tgt == PDS_TGT_FUNC);

   pds_ref_latch_s  ref_lat_r;
   pds_fb_latch_s   fb_lat_r;
   pds_func_latch_s func_lat_r;
   // Code 11 targets nothing and is dropped
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ref_lat_r  <= `PDS_REF_RST;
         fb_lat_r   <= `PDS_FB_RST;
         func_lat_r <= `PDS_FUNC_RST;
      end else begin
         if (wr_ref)  ref_lat_r  <= shift_r;
         if (wr_fb)   fb_lat_r   <= shift_r;
         if (wr_func) func_lat_r <= shift_r;
      end
   end

   // Control decode
   wire        hold_cnt  = func_lat_r.counter_reset | func_lat_r.power_down;
   wire        ref_live  = ~func_lat_r.power_down;
   wire [13:0] r_div     = (ref_lat_r.ref_div == 14'h0000) ? 14'h0001 : ref_lat_r.ref_div;
   wire [12:0] b_div     = fb_lat_r.main_div;
   wire [5:0]  a_div     = fb_lat_r.swallow_div;
   wire [6:0]  pre_p     = 7'(`PDS_PRE_BASE << func_lat_r.prescale_select);
   // Edges from a disconnected reference stage never reach the divider
   wire        ref_edge  = pin_rise[3] & ref_live;
   wire        rf_edge   = pin_rise[4];

   // Reference divider
   logic [13:0] r_cnt_r;
   logic        ref_pls_r;
   wire         r_term = (r_cnt_r + 14'h0001) >= r_div;
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         r_cnt_r   <= 14'h0000;
         ref_pls_r <= 1'b0;
      end else if (hold_cnt || wr_ref) begin
         r_cnt_r   <= 14'h0000;
         ref_pls_r <= 1'b0;
      end else begin
         ref_pls_r <= ref_edge & r_term;
         if (ref_edge) r_cnt_r <= r_term ? 14'h0000 : r_cnt_r + 14'h0001;
      end
   end

   // Dual-modulus prescaler with swallow and main counters
   logic [6:0]  pre_cnt_r;
   logic [5:0]  a_cnt_r;
   logic [12:0] b_cnt_r;
   logic        fb_pls_r;
   wire         swallow_on = (a_cnt_r != 6'h00);
   wire [6:0]   pre_last   = swallow_on ? pre_p : pre_p - 7'h01;
   wire         pre_pls    = rf_edge && (pre_cnt_r == pre_last);
   wire         b_end      = (b_cnt_r <= 13'h0001);
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pre_cnt_r <= 7'h00;
         a_cnt_r   <= 6'h00;
         b_cnt_r   <= 13'h0003;
         fb_pls_r  <= 1'b0;
      end else if (hold_cnt || wr_fb || wr_func) begin
         pre_cnt_r <= 7'h00;
         a_cnt_r   <= a_div;
         b_cnt_r   <= b_div;
         fb_pls_r  <= 1'b0;
      end else begin
         fb_pls_r <= pre_pls & b_end;
         if (rf_edge) pre_cnt_r <= pre_pls ? 7'h00 : pre_cnt_r + 7'h01;
         if (pre_pls && b_end) begin
            a_cnt_r <= a_div;
            b_cnt_r <= b_div;
         end else if (pre_pls) begin
            b_cnt_r <= b_cnt_r - 13'h0001;
            if (swallow_on) a_cnt_r <= a_cnt_r - 6'h01;
         end
      end
   end

   // Phase comparator: up on reference, down on feedback, both cleared after backlash
   logic       up_r, dn_r;
   logic [3:0] abl_cnt_r;
   logic [7:0] err_cnt_r;
   wire        both     = up_r & dn_r;
   wire        pfd_done = both && (abl_cnt_r == 4'h0);
   wire [3:0]  abl_load = (ref_lat_r.backlash_width == `PDS_ABP_REC) ? ABP_CYC - 4'h1 : 4'h0;
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         up_r      <= 1'b0;
         dn_r      <= 1'b0;
         abl_cnt_r <= 4'h0;
         err_cnt_r <= 8'h00;
      end else if (hold_cnt) begin
         up_r      <= 1'b0;
         dn_r      <= 1'b0;
         abl_cnt_r <= 4'h0;
         err_cnt_r <= 8'h00;
      end else if (pfd_done) begin
         up_r      <= 1'b0;
         dn_r      <= 1'b0;
         err_cnt_r <= 8'h00;
      end else begin
         up_r <= up_r | ref_pls_r;
         dn_r <= dn_r | fb_pls_r;
         // Width stretched only while both sides are high
         abl_cnt_r <= both ? abl_cnt_r - 4'h1 : abl_load;
         if ((up_r ^ dn_r) && (err_cnt_r != 8'hff)) err_cnt_r <= err_cnt_r + 8'h01;
      end
   end

   // Lock detect, judged once per comparator cycle
   logic [2:0] good_r;
   logic       lock_r;
   wire [7:0]  lock_win = fb_lat_r.lock_precision_select ? FINE_CYC : WIDE_CYC;
   wire        err_ok   = err_cnt_r < lock_win;
   wire        err_bad  = err_cnt_r >= UNLK_CYC;
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         good_r <= 3'h0;
         lock_r <= 1'b0;
      end else if (hold_cnt) begin
         good_r <= 3'h0;
         lock_r <= 1'b0;
      end else if (pfd_done) begin
         if (err_bad) begin
            good_r <= 3'h0;
            lock_r <= 1'b0;
         end else if (err_ok) begin
            if (good_r != `PDS_LOCK_CYCLES) good_r <= good_r + 3'h1;
            if (good_r == `PDS_LOCK_CYCLES - 3'h1) lock_r <= 1'b1;
         end else if (!lock_r) begin
            good_r <= 3'h0;
         end
      end
   end

   // Scaled divider outputs for the monitor, halved to a square wave
   logic ref_half_r, fb_half_r;
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ref_half_r <= 1'b0;
         fb_half_r  <= 1'b0;
      end else begin
         ref_half_r <= ref_half_r ^ ref_pls_r;
         fb_half_r  <= fb_half_r ^ fb_pls_r;
      end
   end

   // Monitor source selection
   wire pds_mon_e mon_sel = pds_mon_e'(func_lat_r.monitor_select);
   logic mon_val, mon_en;
   always_comb begin
      mon_val = 1'b0;
      mon_en  = 1'b1;
      unique case (mon_sel)
         PDS_MON_OFF:      mon_en  = 1'b0;
         PDS_MON_DLOCK:    mon_val = lock_r;
         PDS_MON_FB_DIV:   mon_val = fb_half_r;
         PDS_MON_HIGH:     mon_val = 1'b1;
         PDS_MON_REF_DIV:  mon_val = ref_half_r;
         // Pulls low only while a correction pulse is out; pull-up gives the high
         PDS_MON_ALOCK:    mon_en  = up_r | dn_r;
         PDS_MON_SER_DATA: mon_val = shift_r[23];
         PDS_MON_LOW:      mon_val = 1'b0;
      endcase
   end

   // Registered outputs; polarity swaps the pump directions
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pump_up       <= 1'b0;
         pump_dn       <= 1'b0;
         pump_tristate <= 1'b0;
         pump_current  <= 3'h0;
         lock_detect   <= 1'b0;
         ref_stage_en  <= 1'b0;
         monitor_o     <= 1'b0;
         monitor_oe    <= 1'b0;
      end else begin
         pump_up       <= func_lat_r.pd_polarity ? up_r & ~dn_r : dn_r & ~up_r;
         pump_dn       <= func_lat_r.pd_polarity ? dn_r & ~up_r : up_r & ~dn_r;
         pump_tristate <= func_lat_r.pump_tristate;
         pump_current  <= func_lat_r.pump_current_sel;
         lock_detect   <= lock_r;
         ref_stage_en  <= ref_live;
         monitor_o     <= mon_val;
         monitor_oe    <= mon_en;
      end
   end

endmodule // pds_synth_ctrl

// File: bench/pds_synth_ctrl_checker.sv
// Purpose: Port-level checks of the synthesizer control block
// Assumes: Only top ports visible; pins pass a two-stage synchronizer
// Notes:   Load checks lean on a strobe held high for several clocks
`timescale 1ns/100ps
module pds_synth_ctrl_checker (
   // Clock and reset
   input wire logic          clk,
   input wire logic          rst_n,
   // Pins in
   input wire logic          ser_clk,
   input wire logic          ser_data,
   input wire logic          latch_load_strobe,
   input wire logic          reference_input,
   input wire logic          rf_input,
   // Pins out
   input wire logic          pump_up,
   input wire logic          pump_dn,
   input wire logic          pump_tristate,
   input pds_pkg::pds_cur_t  pump_current,
   input wire logic          lock_detect,
   input wire logic          ref_stage_en,
   input wire logic          monitor_o,
   input wire logic          monitor_oe
);
   import pds_pkg::*;
   logic       ref_q_r;
   logic [2:0] ref_cnt_r;
   logic [1:0] err_run_r;
   logic [3:0] err_t_r;
   // Edge and one-sided pump detection
   wire        ref_rise = reference_input & ~ref_q_r;
   wire        one_side = pump_up ^ pump_dn;
   // Reference rises since reset; recent long error, with slack for latency
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ref_q_r   <= 1'b0;
         ref_cnt_r <= 3'h0;
         err_run_r <= 2'h0;
         err_t_r   <= 4'h0;
      end else begin
         ref_q_r   <= reference_input;
         ref_cnt_r <= ref_cnt_r + {2'h0, ref_rise & (ref_cnt_r != 3'h7)};
         err_run_r <= one_side ? err_run_r + {1'b0, err_run_r != 2'h3} : 2'h0;
         err_t_r   <= (err_run_r >= 2'h2) ? 4'hf : err_t_r - {3'h0, err_t_r != 4'h0};
      end
   end
   // Overlap is masked at the pump outputs, so both pumps never show at once
   AST_BACKLASH_END: assert property (@(posedge clk) disable iff (!rst_n)
      !(pump_up && pump_dn)) else $error("pumps overlap");
   AST_CUR_LOAD: assert property (@(posedge clk) disable iff (!rst_n)
      $changed(pump_current) |-> $past(latch_load_strobe, 2)) else $error("current moved");
   AST_TRI_LOAD: assert property (@(posedge clk) disable iff (!rst_n)
      $changed(pump_tristate) |-> $past(latch_load_strobe, 2)) else $error("tristate moved");
   AST_PDN_LOAD: assert property (@(posedge clk) disable iff (!rst_n)
      $changed(ref_stage_en) && $past(rst_n, 4) |-> $past(latch_load_strobe, 2))
      else $error("ref stage moved");
   AST_LOCK_MIN: assert property (@(posedge clk) disable iff (!rst_n)
      $rose(lock_detect) |-> ref_cnt_r >= 3'h5) else $error("lock too early");
   AST_LOCK_HOLD: assert property (@(posedge clk) disable iff (!rst_n)
      $fell(lock_detect) |-> err_t_r != 4'h0) else $error("lock lost without error");
   AST_MON_EN: assert property (@(posedge clk) disable iff (!rst_n)
      $rose(monitor_oe) |-> $past(latch_load_strobe, 2) || $past(one_side | pump_up)
      || pump_up || pump_dn) else $error("monitor enable rose");
   AST_RESET_OUT: assert property (@(posedge clk) disable iff (!rst_n)
      $rose(rst_n) |-> !lock_detect && !pump_up && !pump_dn && !monitor_oe)
      else $error("outputs not clear");
endmodule // pds_synth_ctrl_checker
bind pds_synth_ctrl pds_synth_ctrl_checker pds_synth_ctrl_checker_inst (
   .clk(clk), .rst_n(rst_n), .ser_clk(ser_clk), .ser_data(ser_data),
   .latch_load_strobe(latch_load_strobe), .reference_input(reference_input),
   .rf_input(rf_input), .pump_up(pump_up), .pump_dn(pump_dn),
   .pump_tristate(pump_tristate), .pump_current(pump_current),
   .lock_detect(lock_detect), .ref_stage_en(ref_stage_en),
   .monitor_o(monitor_o), .monitor_oe(monitor_oe));

// File: bench/pds_host_model.sv
// Purpose: Host end of the three-wire programming link
// Assumes: 160 ns link clock that stands still between words
// Notes:   Data is inverted once hold has run out, so no stale bit lingers
`timescale 1ns/100ps
module pds_host_model (
   // Three-wire link
   output logic ser_clk,
   output logic ser_data,
   output logic latch_load_strobe
);
   import pds_pkg::*;
   // Link idle
   initial begin
      ser_clk = 1'b0;
      ser_data = 1'b0;
      latch_load_strobe = 1'b0;
   end
   // One word, bit 23 first, then a long strobe
   task automatic send(input logic [23:0] w);
      for (int i = 23; i >= 0; i--) begin
         ser_data = w[i];
         #80 ser_clk = 1'b1;
         #40 ser_data = ~w[i];
         #40 ser_clk = 1'b0;
      end
      #40 latch_load_strobe = 1'b1;
      #80 latch_load_strobe = 1'b0;
      #80;
   endtask
endmodule // pds_host_model

// File: bench/pds_synth_ctrl_tb.sv
// Purpose: Self-checking bench for the synthesizer control block
// Assumes: Reference and RF pins share one 40 ns square wave
// Notes:   Divide ratios are read off the monitor pin at half rate
`timescale 1ns/100ps
module pds_synth_ctrl_tb;
   import pds_pkg::*;
   logic       clk, rst_n, ser_clk, ser_data, latch_load_strobe, wave, m;
   logic       pump_up, pump_dn, pump_tristate, lock_detect, ref_stage_en;
   logic       monitor_o, monitor_oe;
   pds_cur_t   pump_current;
   logic [1:0] ph;
   int         rises, cyc, fail_count, checks, n, k, r0;
   pds_mon_e   mon_tbl [4] = '{PDS_MON_OFF, PDS_MON_HIGH, PDS_MON_SER_DATA, PDS_MON_LOW};
   pds_synth_ctrl pds_synth_ctrl_inst (.clk(clk), .rst_n(rst_n), .ser_clk(ser_clk),
      .ser_data(ser_data), .latch_load_strobe(latch_load_strobe),
      .reference_input(wave), .rf_input(wave), .pump_up(pump_up), .pump_dn(pump_dn),
      .pump_tristate(pump_tristate), .pump_current(pump_current),
      .lock_detect(lock_detect), .ref_stage_en(ref_stage_en),
      .monitor_o(monitor_o), .monitor_oe(monitor_oe));
   pds_host_model pds_host_model_inst (.ser_clk(ser_clk), .ser_data(ser_data),
      .latch_load_strobe(latch_load_strobe));
   // Clock
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   // Divider wave, its rises counted as sent, and the hang limit
   always @(posedge clk) begin
      ph <= ph + 2'h1;
      wave <= ~ph[1];
      if (ph == 2'h0) rises <= rises + 1;
      cyc <= cyc + 1;
      if (cyc == 60000) begin
         fail_count = fail_count + 1;
         end_of_test();
      end
   end
   // Word builders; reserved bits zero, recommended backlash code
   function automatic logic [23:0] ref_w(input logic [13:0] r);
      return {6'h00, 2'h2, r, 2'h0};
   endfunction
   function automatic logic [23:0] fb_w(input logic p, input logic [12:0] b,
                                        input logic [5:0] a);
      return {1'b0, p, 1'b0, b, a, 2'h1};
   endfunction
   function automatic logic [23:0] fn_w(input logic [1:0] p, input logic [2:0] c,
                                        input logic t, input logic d, input logic [2:0] mo);
      return {p, 4'h0, c, 6'h00, t, 1'b1, mo, d, 1'b0, 2'h2};
   endfunction
   task automatic chk(input string nm, input logic [23:0] exp, input logic [23:0] got);
      checks = checks + 1;
      if (got !== exp) begin
         fail_count = fail_count + 1;
         $display("Error %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic wr(input logic [23:0] w);
      pds_host_model_inst.send(w);
      @(posedge clk);
      #1;
   endtask
   // Count wave rises between the second and third monitor toggles
   task automatic meas(input int exp);
      for (int i = 0; i < 3; i++) begin
         m = monitor_o;
         r0 = rises;
         while (monitor_o === m) begin
            @(posedge clk);
            #1;
         end
      end
      chk("divide", 24'(exp), 24'(rises - r0));
   endtask
   task automatic end_of_test();
      $display("Checks %0d mismatches %0d", checks, fail_count);
      if (fail_count == 0 && checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   // Main sequence
   initial begin
      rst_n = 1'b0;
      ph = 2'h0;
      wave = 1'b0;
      rises = 0;
      cyc = 0;
      fail_count = 0;
      checks = 0;
      repeat (4) @(posedge clk);
      rst_n <= 1'b1;
      repeat (4) @(posedge clk);
      for (k = 0; k < 8; k++) begin
         wr(fn_w(2'h2, k[2:0], k[0], k[1], mon_tbl[k[1:0]]));
         chk("pump_current", 24'(k), 24'(pump_current));
         chk("tristate", 24'(k[0]), 24'(pump_tristate));
         chk("ref_stage_en", 24'(!k[1]), 24'(ref_stage_en));
         chk("monitor", 24'({k[1:0] != 2'h0, ^k[1:0]}), 24'({monitor_oe, monitor_oe & monitor_o}));
      end
      wr(fn_w(2'h2, 3'h2, 1'b0, 1'b0, 3'h3) | 24'h000003);
      chk("ignored", 24'h7, 24'(pump_current));
      // Slow divider wave keeps the prescaler output far below its limit
      for (k = 0; k < 4; k++) begin
         wr(fn_w(k[1:0], 3'h0, 1'b0, 1'b0, 3'h2));
         // Swallow must not exceed main, or N = B*P + A no longer holds
         wr(fb_w(1'b0, (k == 0) ? 13'd63 : 13'd4, (k == 0) ? 6'd63 : 6'(k)));
         meas(((k == 0) ? 63 : 4) * (8 << k) + ((k == 0) ? 63 : k));
      end
      wr(fn_w(2'h0, 3'h0, 1'b0, 1'b0, 3'h4));
      for (k = 1; k < 4; k++) begin
         wr(ref_w(14'(k * 3 - 2)));
         meas(k * 3 - 2);
      end
      for (k = 0; k < 2; k++) begin
         wr(ref_w(14'd24));
         wr(fb_w(k[0], 13'd3, 6'h00));
         // Counter reset then release restarts both dividers in phase
         wr(fn_w(2'h0, 3'h0, 1'b0, 1'b0, 3'h1) | 24'h000004);
         wr(fn_w(2'h0, 3'h0, 1'b0, 1'b0, 3'h1));
         for (n = 0; n < 2000 && lock_detect !== 1'b1; n++) @(posedge clk);
         #1 chk("lock", 24'h1, 24'(lock_detect));
         chk("monitor_lock", 24'h1, 24'(monitor_o & monitor_oe));
         wr(ref_w(14'd25));
         for (n = 0; n < 2000 && lock_detect !== 1'b0; n++) @(posedge clk);
         #1 chk("unlock", 24'h0, 24'(lock_detect));
      end
      end_of_test();
   end
endmodule // pds_synth_ctrl_tb
